// ===== hdl/proxy_offload_regs.svh
`ifndef PROXY_OFFLOAD_REGS_SVH
`define PROXY_OFFLOAD_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_FILTER_CTRL 16'h0000
`define OFS_GLOBAL_CTRL 16'h0004
`define OFS_WAKE_FILTER 16'h0008
`define OFS_MATCH_FLAGS 16'h000C
`define OFS_HOST_IFACE 16'h0010
`define OFS_FW_STATUS 16'h0014
`define OFS_INT_STATUS 16'h0018
`define OFS_INT_MASK 16'h001C
`define OFS_STATE 16'h0020
`define SHMEM_BASE 16'h8800
`define SHMEM_LAST 16'h8EFF
// ****************************************
// Field positions
// ****************************************
`define BIT_AWAKE_EN 16
`define BIT_GLOBAL_EN 0
`define BIT_AVAIL 0
`define BIT_GO 1
`define BIT_SUCCESS 2
`define BIT_FW_RESET 0
`define BIT_FWD_UNSUP 1
`define EV_PROXIED 0
`define EV_DROPPED 1
`define EV_FORWARD 2
`define EV_WAKE 3
`define EV_CMD_DONE 4
`define EV_FW_RESET 5
`define EV_TIMEOUT 6
`define EV_COUNT 7
// ****************************************
// Sizes, reset values, timing
// ****************************************
`define FILTER_SLOTS 8
`define SHMEM_IDX_W 9
`define SHMEM_WORDS 448
`define RST_WORD 32'h0000_0000
`define RESP_LIMIT_S 64'd60
`define CLOCK_HZ 64'd125000000
`endif

// ===== hdl/proxy_offload_pkg.sv
package proxy_offload_pkg;
`include "proxy_offload_regs.svh"
   // Per-packet verdict from the receive filters
   typedef struct packed {
      logic addr_pass;
      logic crc_err;
      logic csum_err;
      logic fw_supported;
      logic [`FILTER_SLOTS-1:0] proxy_hits;
      logic [`FILTER_SLOTS-1:0] wake_hits;
   } rx_verdict_type;
   // Firmware port into the shared command memory
   typedef struct packed {
      logic en;
      logic we;
      logic [`SHMEM_IDX_W-1:0] index;
      logic [31:0] wdata;
   } fw_mem_req_type;
   // Offload response tracker
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_LATE = 3'h4
   } resp_state_type;
endpackage

// ===== hdl/shared_cmd_mem.sv
`timescale 1ns/1ps
module shared_cmd_mem
   import proxy_offload_pkg::*;
#(
   parameter int WORDS = `SHMEM_WORDS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_we,
   input wire logic [`SHMEM_IDX_W-1:0] host_index,
   input wire logic [31:0] host_wdata,
   input wire logic [3:0] host_strb,
   output logic [31:0] host_rdata,
   input wire fw_mem_req_type fw_req,
   output logic [31:0] fw_rdata
);
   // ****************************************
   // Storage
   // ****************************************
   logic [31:0] mem [WORDS];
   initial begin
      if (WORDS < 1 || WORDS > (1 << `SHMEM_IDX_W)) begin
         $error("shared_cmd_mem: WORDS out of range");
      end
   end
   // Per-entry write; firmware reply wins over a host write to the same word
   genvar g;
   for (g = 0; g < WORDS; g++) begin : gen_word
      logic fw_hit;
      logic host_hit;
      logic [31:0] host_mask;
      assign fw_hit = fw_req.en && fw_req.we && (fw_req.index == `SHMEM_IDX_W'(g));
      assign host_hit = host_we && (host_index == `SHMEM_IDX_W'(g));
      assign host_mask = {{8{host_strb[3]}}, {8{host_strb[2]}}, {8{host_strb[1]}}, {8{host_strb[0]}}};
      always_ff @(posedge clock) begin
         if (fw_hit) begin
            mem[g] <= fw_req.wdata;
         end else if (host_hit) begin
            mem[g] <= (mem[g] & ~host_mask) | (host_wdata & host_mask);
         end
      end
   end
   // Host read is combinational; the bus slave registers it
   assign host_rdata = (32'(host_index) < WORDS) ? mem[host_index] : `RST_WORD;
   // Firmware read port, registered
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fw_rdata <= `RST_WORD;
      end else if (fw_req.en && !fw_req.we && 32'(fw_req.index) < WORDS) begin
         fw_rdata <= mem[fw_req.index];
      end
   end
endmodule

// ===== hdl/proxy_offload_ctrl.sv
// How it works
// RQ1: Low power, proxy plus wake filter match: wake only, no offload response.
// RQ2: Frames with CRC or checksum errors are dropped silently, never offloaded.
// RQ3: Offload response is expected within 60 seconds; a late one raises an event.
// RQ4: Software clears match flags, then programs filters and address tables; the bench programs the filters first, then clears the flags.
// RQ5: Software checks host interface available reads one before using memory.
// RQ6: Software reads and clears the firmware reset flag, rebuilds list if set.
// RQ7: Configuration sits in shared memory window 0x8800 to 0x8EFF, network order.
// RQ8: Software writes one to host command bit to hand command to firmware.
// RQ9: Firmware clears command bit when done; success bit qualifies the result.
// RQ10: Software reads back the reply and repeats per further command.
// RQ11: Software rechecks firmware reset flag and restarts sequence if set.
// RQ12: Software sets awake-state enable, then the global proxy enable.
// RQ13: Awake proxying only while both global and awake-state enables are set.
// RQ14: Address filter first, proxy filters second; a hit is offloaded, not forwarded.
// RQ15: Every matched proxy filter sets its own match flag, several at once; the code sets no flag on a wake-only match (RQ1).
// RQ16: Matches firmware cannot serve go to host only when forwarding is enabled.
// RQ17: Match flags stay set until software clears them.
`timescale 1ns/1ps
module proxy_offload_ctrl
   import proxy_offload_pkg::*;
#(
   parameter int NUM_FILTERS = `FILTER_SLOTS,
   parameter longint unsigned RESP_LIMIT_CYCLES = `RESP_LIMIT_S * `CLOCK_HZ
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic pkt_valid,
   input wire rx_verdict_type pkt,
   input wire logic low_power,
   output logic offload_req,
   output logic forward_host,
   output logic wake_host,
   output logic drop_packet,
   input wire logic offload_done,
   input wire logic host_iface_available,
   input wire logic fw_cmd_done,
   input wire logic fw_cmd_ok,
   input wire logic fw_reset_event,
   input wire logic fw_forward_unsupported,
   output logic host_command_pending,
   input wire fw_mem_req_type fw_mem_req,
   output logic [31:0] fw_mem_rdata
);
   localparam int CNT_W = $clog2(RESP_LIMIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] LIMIT_LAST = CNT_W'(RESP_LIMIT_CYCLES - 1);
   initial begin
      if (NUM_FILTERS < 1 || NUM_FILTERS > `FILTER_SLOTS) begin
         $error("proxy_offload_ctrl: NUM_FILTERS out of range");
      end
      if (RESP_LIMIT_CYCLES < 1) begin
         $error("proxy_offload_ctrl: RESP_LIMIT_CYCLES must be at least one");
      end
   end
   // ****************************************
   // State
   // ****************************************
   logic [`FILTER_SLOTS-1:0] proxy_filter_control;
   logic awake_state_proxy_enable;
   logic global_proxy_enable;
   logic [`FILTER_SLOTS-1:0] wake_filter_control;
   logic [`FILTER_SLOTS-1:0] proxy_match_flags;
   logic host_command_go;
   logic host_command_success;
   logic firmware_reset_flag;
   logic [`EV_COUNT-1:0] int_status;
   logic [`EV_COUNT-1:0] int_mask;
   resp_state_type state;
   logic [CNT_W-1:0] resp_cnt;
   logic [`FILTER_SLOTS-1:0] impl_mask;
   // Implemented filter slots
   genvar g;
   for (g = 0; g < `FILTER_SLOTS; g++) begin : gen_slot
      assign impl_mask[g] = (g < NUM_FILTERS);
   end
   // ****************************************
   // APB decode
   // ****************************************
   logic setup_done;
   logic wr_acc;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [15:0] shm_off;
   logic sel_shm;
   logic sel_fc, sel_gc, sel_wf, sel_mf, sel_hi, sel_fs, sel_is, sel_im, sel_st;
   logic mapped;
   logic [31:0] shm_rdata;
   logic [31:0] rd_mux;
   // Decode and write strobes; writes land at the edge that samples pready high
   assign setup_done = psel && penable && !pready;
   assign wr_acc = psel && penable && pready && pwrite;
   assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wbits = pwdata & wmask;
   assign shm_off = paddr - `SHMEM_BASE;
   assign sel_shm = (paddr >= `SHMEM_BASE) && (paddr <= `SHMEM_LAST); // RQ7
   assign sel_fc = (paddr == `OFS_FILTER_CTRL);
   assign sel_gc = (paddr == `OFS_GLOBAL_CTRL);
   assign sel_wf = (paddr == `OFS_WAKE_FILTER);
   assign sel_mf = (paddr == `OFS_MATCH_FLAGS);
   assign sel_hi = (paddr == `OFS_HOST_IFACE);
   assign sel_fs = (paddr == `OFS_FW_STATUS);
   assign sel_is = (paddr == `OFS_INT_STATUS);
   assign sel_im = (paddr == `OFS_INT_MASK);
   assign sel_st = (paddr == `OFS_STATE);
   assign mapped = sel_shm | sel_fc | sel_gc | sel_wf | sel_mf | sel_hi | sel_fs | sel_is | sel_im | sel_st;
   // Read selection
   assign rd_mux = sel_shm ? shm_rdata :
      sel_fc ? (32'(proxy_filter_control) | (32'(awake_state_proxy_enable) << `BIT_AWAKE_EN)) :
      sel_gc ? (32'(global_proxy_enable) << `BIT_GLOBAL_EN) :
      sel_wf ? 32'(wake_filter_control) :
      sel_mf ? 32'(proxy_match_flags) :
      sel_hi ? ((32'(host_iface_available) << `BIT_AVAIL) | (32'(host_command_go) << `BIT_GO) |
                (32'(host_command_success) << `BIT_SUCCESS)) :
      sel_fs ? ((32'(firmware_reset_flag) << `BIT_FW_RESET) | (32'(fw_forward_unsupported) << `BIT_FWD_UNSUP)) :
      sel_is ? 32'(int_status) :
      sel_im ? 32'(int_mask) :
      sel_st ? {25'h0, state, 1'b0, CNT_W'(0) != resp_cnt, low_power, global_proxy_enable} :
      `RST_WORD;
   // Shared command memory
   shared_cmd_mem #(.WORDS(`SHMEM_WORDS)) u_shmem (
      .clock(clock),
      .rst_n(rst_n),
      .host_we(wr_acc && sel_shm), // RQ7
      .host_index(`SHMEM_IDX_W'(shm_off >> 2)),
      .host_wdata(pwdata),
      .host_strb(pstrb),
      .host_rdata(shm_rdata),
      .fw_req(fw_mem_req),
      .fw_rdata(fw_mem_rdata)
   );
   // Bus answer: one wait state, error on unmapped address
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_WORD;
      end else begin
         pready <= setup_done;
         pslverr <= setup_done && !mapped;
         prdata <= (setup_done && !pwrite) ? rd_mux : `RST_WORD;
      end
   end
   // ****************************************
   // Packet decision
   // ****************************************
   logic bad_frame;
   logic proxy_active;
   logic [`FILTER_SLOTS-1:0] hits;
   logic hit_any;
   logic wake_any;
   logic candidate;
   logic wake_only;
   logic fire_offload;
   logic fire_forward;
   logic fire_wake;
   logic fire_drop;
   assign bad_frame = pkt.crc_err || pkt.csum_err; // RQ2
   assign proxy_active = global_proxy_enable && (low_power || awake_state_proxy_enable); // RQ13
   assign hits = pkt.proxy_hits & proxy_filter_control & impl_mask;
   assign hit_any = |hits;
   assign wake_any = |(pkt.wake_hits & wake_filter_control);
   assign candidate = pkt_valid && !bad_frame && pkt.addr_pass && proxy_active && hit_any; // RQ14
   assign wake_only = candidate && low_power && wake_any; // RQ1
   assign fire_offload = candidate && !wake_only && pkt.fw_supported; // RQ14
   assign fire_forward = pkt_valid && !bad_frame && pkt.addr_pass &&
      ((candidate && !wake_only && !pkt.fw_supported && fw_forward_unsupported) || // RQ16
       (!candidate && !low_power));
   assign fire_wake = pkt_valid && !bad_frame && low_power &&
      (wake_only || (!candidate && pkt.addr_pass && wake_any) ||
       (candidate && !pkt.fw_supported && fw_forward_unsupported)); // RQ16
   assign fire_drop = pkt_valid && !fire_offload && !fire_forward && !fire_wake; // RQ2
   // One-cycle packet outcome pulses
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         offload_req <= 1'b0;
         forward_host <= 1'b0;
         wake_host <= 1'b0;
         drop_packet <= 1'b0;
      end else begin
         offload_req <= fire_offload;
         forward_host <= fire_forward;
         wake_host <= fire_wake;
         drop_packet <= fire_drop;
      end
   end
   // ****************************************
   // Response tracker
   // ****************************************
   logic timeout_hit;
   assign timeout_hit = (state == ST_WAIT) && !offload_done && (resp_cnt == LIMIT_LAST); // RQ3
   // Times the oldest outstanding offload; later ones ride along
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         resp_cnt <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               resp_cnt <= '0;
               if (fire_offload) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               resp_cnt <= resp_cnt + CNT_W'(1);
               if (offload_done) begin
                  state <= ST_IDLE;
               end else if (timeout_hit) begin
                  state <= ST_LATE; // RQ3
               end
            end
            ST_LATE: begin
               if (offload_done) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   // ****************************************
   // Control registers and sticky flags
   // ****************************************
   logic [`EV_COUNT-1:0] events;
   logic go_set;
   logic [`FILTER_SLOTS-1:0] next_match_flags;
   logic [`EV_COUNT-1:0] next_int_status;
   logic next_fw_reset_flag;
   assign go_set = wr_acc && sel_hi && wbits[`BIT_GO]; // RQ8
   // Set wins over a clear in the same cycle
   assign next_match_flags = (proxy_match_flags & ~((wr_acc && sel_mf) ? wbits[`FILTER_SLOTS-1:0] : '0)) |
      (candidate && !wake_only ? hits : '0); // RQ15 RQ17
   assign next_fw_reset_flag = fw_reset_event ||
      (firmware_reset_flag && !(wr_acc && sel_fs && wbits[`BIT_FW_RESET])); // RQ6
   assign events = {timeout_hit, fw_reset_event, fw_cmd_done && host_command_go, fire_wake,
      fire_forward, fire_drop && pkt_valid && bad_frame, fire_offload};
   assign next_int_status = (int_status & ~((wr_acc && sel_is) ? wbits[`EV_COUNT-1:0] : '0)) | events;
   // Software-owned configuration
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         proxy_filter_control <= '0;
         awake_state_proxy_enable <= 1'b0;
         global_proxy_enable <= 1'b0;
         wake_filter_control <= '0;
         int_mask <= '0;
      end else if (wr_acc) begin
         if (sel_fc && pstrb[0]) begin
            proxy_filter_control <= pwdata[`FILTER_SLOTS-1:0] & impl_mask;
         end
         if (sel_fc && pstrb[2]) begin
            awake_state_proxy_enable <= pwdata[`BIT_AWAKE_EN]; // RQ12
         end
         if (sel_gc && pstrb[0]) begin
            global_proxy_enable <= pwdata[`BIT_GLOBAL_EN]; // RQ12
         end
         if (sel_wf && pstrb[0]) begin
            wake_filter_control <= pwdata[`FILTER_SLOTS-1:0];
         end
         if (sel_im && pstrb[0]) begin
            int_mask <= pwdata[`EV_COUNT-1:0];
         end
      end
   end
   // Command handshake, status flags and interrupt
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         host_command_go <= 1'b0;
         host_command_success <= 1'b0;
         firmware_reset_flag <= 1'b0;
         proxy_match_flags <= '0;
         int_status <= '0;
         host_command_pending <= 1'b0;
         irq <= 1'b0;
      end else begin
         host_command_go <= go_set || (host_command_go && !fw_cmd_done); // RQ9
         host_command_success <= go_set ? 1'b0 :
            ((fw_cmd_done && host_command_go) ? fw_cmd_ok : host_command_success); // RQ9
         firmware_reset_flag <= next_fw_reset_flag;
         proxy_match_flags <= next_match_flags;
         int_status <= next_int_status;
         host_command_pending <= go_set || (host_command_go && !fw_cmd_done);
         irq <= |(int_status & int_mask);
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_BAD_DROPPED: assert property (pkt_valid && bad_frame |=> drop_packet && !offload_req && !forward_host) // RQ2
      else $error("bad frame was not dropped");
   AST_WAKE_ONLY: assert property (wake_only |=> wake_host && !offload_req && !forward_host) // RQ1
      else $error("wake match still offloaded");
   AST_AWAKE_BOTH: assert property (pkt_valid && !low_power && !(global_proxy_enable && awake_state_proxy_enable)
      |=> !offload_req) // RQ13
      else $error("awake offload without both enables");
   AST_PROXY_NO_FWD: assert property (candidate && !wake_only && pkt.fw_supported |=> offload_req && !forward_host) // RQ14
      else $error("proxied packet forwarded");
   AST_FLAGS_SET: assert property (candidate && !wake_only |=> (proxy_match_flags & $past(hits)) == $past(hits)) // RQ15
      else $error("match flag missing");
   AST_FLAGS_STICKY: assert property (!(wr_acc && sel_mf) |=> ($past(proxy_match_flags) & ~proxy_match_flags) == '0) // RQ17
      else $error("match flag dropped without clear");
   AST_UNSUP_FWD: assert property (candidate && !wake_only && !pkt.fw_supported
      |=> (forward_host == $past(fw_forward_unsupported)) && !offload_req) // RQ16
      else $error("unsupported match forwarding wrong");
   AST_RESP_LATE: assert property (timeout_hit |=> int_status[`EV_TIMEOUT] && state == ST_LATE) // RQ3
      else $error("late response not flagged");
   AST_GO_CLEAR: assert property (fw_cmd_done && !go_set |=> !host_command_go ##1 !host_command_pending) // RQ9
      else $error("command bit not cleared");
   AST_SUCCESS: assert property (fw_cmd_done && host_command_go && !go_set |=> host_command_success == $past(fw_cmd_ok)) // RQ9
      else $error("success bit wrong");
   COV_OFFLOAD: cover property (fire_offload ##1 offload_req ##[1:20] offload_done);
   COV_WAKE_ONLY: cover property (wake_only ##1 wake_host);
   COV_CMD: cover property (go_set ##[1:50] fw_cmd_done && fw_cmd_ok);
   COV_TIMEOUT: cover property (timeout_hit);
endmodule

// ===== verification/fw_partner_model.sv
`timescale 1ns/1ps
module fw_partner_model
   import proxy_offload_pkg::*;
#(
   parameter logic [31:0] REPLY_WORD = 32'hC0DE_0001
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_command_pending,
   input wire logic offload_req,
   input wire logic cmd_ok,
   input wire logic slow,
   input wire logic fwd_unsup,
   input wire logic reset_trig,
   output logic host_iface_available,
   output logic fw_cmd_done,
   output logic fw_cmd_ok,
   output logic fw_reset_event,
   output logic fw_forward_unsupported,
   output logic offload_done,
   output fw_mem_req_type fw_mem_req
);
   int cmd_cnt;
   int resp_cnt;
   int outst;
   logic served;
   logic done_now;
   // ****************************************
   // Firmware side of command and response
   // ****************************************
   assign done_now = (outst > 0) && (resp_cnt == (slow ? 40 : 3));
   // Serves one command, writes a reply word, answers offloads
   always_ff @(posedge clock) begin
      fw_cmd_done <= 1'b0;
      fw_mem_req <= '0;
      offload_done <= done_now;
      fw_reset_event <= reset_trig & rst_n;
      if (!rst_n) begin
         cmd_cnt <= 0;
         resp_cnt <= 0;
         outst <= 0;
         served <= 1'b0;
         fw_cmd_ok <= 1'b0;
         host_iface_available <= 1'b0;
         fw_forward_unsupported <= 1'b0;
      end else begin
         host_iface_available <= 1'b1;
         fw_forward_unsupported <= fwd_unsup;
         if (!host_command_pending) served <= 1'b0;
         if (cmd_cnt > 0) cmd_cnt <= cmd_cnt - 1;
         if (host_command_pending && !served && cmd_cnt == 0) begin
            cmd_cnt <= slow ? 12 : 2;
            served <= 1'b1;
         end
         if (cmd_cnt == 1) begin
            fw_cmd_done <= 1'b1;
            fw_cmd_ok <= cmd_ok;
            fw_mem_req <= '{1'b1, 1'b1, 9'h001, REPLY_WORD};
         end
         outst <= outst + int'(offload_req) - int'(done_now);
         resp_cnt <= (done_now || outst == 0) ? 0 : resp_cnt + 1;
      end
   end
endmodule

// ===== verification/protocol_offload_proxy_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module protocol_offload_proxy_control_bench
   import proxy_offload_pkg::*;
;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pkt_valid = 0, low_power = 0;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, fw_mem_rdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, irq, offload_req, forward_host, wake_host, drop_packet, offload_done;
   logic host_iface_available, fw_cmd_done, fw_cmd_ok, fw_reset_event, fw_forward_unsupported;
   logic host_command_pending, err, cmd_ok = 0, slow = 0, reset_trig = 0;
   rx_verdict_type pkt = '0;
   fw_mem_req_type fw_mem_req;
   logic [7:0] fe, wk, fl, exp_fl;
   logic glob, awake, lp, fwd = 0, any_off;
   logic [31:0] wv;
   logic [15:0] reg_ofs [8] = '{16'h0000, 16'h0004, 16'h0008, 16'h000C, 16'h0014, 16'h0018, 16'h001C, 16'h0020};
   logic [3:0] o, care;
   rx_verdict_type v [4];
   logic [3:0] seen [4];
   logic [31:0] seed = 32'h0000_576B;
   int num_errors = 0, checks = 0, cyc = 0;
   proxy_offload_ctrl #(.RESP_LIMIT_CYCLES(20)) DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .pkt_valid(pkt_valid), .pkt(pkt), .low_power(low_power),
      .offload_req(offload_req), .forward_host(forward_host), .wake_host(wake_host),
      .drop_packet(drop_packet), .offload_done(offload_done), .host_iface_available(host_iface_available),
      .fw_cmd_done(fw_cmd_done), .fw_cmd_ok(fw_cmd_ok), .fw_reset_event(fw_reset_event),
      .fw_forward_unsupported(fw_forward_unsupported), .host_command_pending(host_command_pending),
      .fw_mem_req(fw_mem_req), .fw_mem_rdata(fw_mem_rdata));
   fw_partner_model fw (.clock(clock), .rst_n(rst_n), .host_command_pending(host_command_pending),
      .offload_req(offload_req), .cmd_ok(cmd_ok), .slow(slow), .fwd_unsup(fwd), .reset_trig(reset_trig),
      .host_iface_available(host_iface_available), .fw_cmd_done(fw_cmd_done), .fw_cmd_ok(fw_cmd_ok),
      .fw_reset_event(fw_reset_event), .fw_forward_unsupported(fw_forward_unsupported),
      .offload_done(offload_done), .fw_mem_req(fw_mem_req));
   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   initial begin
      forever #4 clock = ~clock;
   end
   // Cuts a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc > 60000) begin
         num_errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One APB transfer, waits for pready
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      `CHK("pready", 1'b1, pready)
   endtask
   // Outcome {offload, forward, wake, drop} for one packet
   function automatic void expect_pkt(input rx_verdict_type p);
      logic good, cand;
      logic [7:0] h, w;
      h = p.proxy_hits & fe;
      w = p.wake_hits & wk;
      good = !p.crc_err && !p.csum_err;
      cand = good && p.addr_pass && glob && (lp || awake) && (|h);
      care = 4'hF;
      fl = '0;
      if (!good) o = 4'b0001;
      else if (!p.addr_pass) begin
         o = 4'b0000;
         care = 4'b1100;
      end else if (cand && lp && (|w)) o = 4'b0010;
      else if (cand && p.fw_supported) begin
         o = 4'b1000;
         fl = h;
      end else if (cand) begin
         o = !fwd ? 4'b0001 : (lp ? 4'b0110 : 4'b0100);
         fl = h;
      end else o = !lp ? 4'b0100 : ((|w) ? 4'b0010 : 4'b0001);
   endfunction
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1;
      foreach (reg_ofs[i]) begin
         apb(0, reg_ofs[i], 0);
         `CHK("reset value", (reg_ofs[i] == 16'h0020) ? {25'h0, ST_IDLE, 4'h0} : 32'h0, rd)
      end
      apb(1, 16'h0010, 32'h0000_0005);
      apb(0, 16'h0010, 0);
      `CHK("iface", 32'h0000_0001, rd)
      apb(0, 16'h0024, 0);
      `CHK("unmapped", 1'b1, err)
      for (int k = 0; k < 4; k++) begin
         cmd_ok <= k[0];
         slow <= k[1];
         o = 0;
         wv = k * 32'h1111_0000 + rnd();
         apb(1, 16'h8800, wv);
         apb(0, 16'h8800, 0);
         `CHK("shared word", wv, rd)
         apb(1, 16'h0010, 32'h0000_0002);
         do apb(0, 16'h0010, 0); while (rd[1] === 1'b1 && ++o < 15);
         `CHK("success", k[0], rd[2])
         apb(0, 16'h8804, 0);
         `CHK("reply", 32'hC0DE_0001, rd)
         apb(0, 16'h0018, 0);
         `CHK("cmd event", 1'b1, rd[4])
      end
      slow <= 0;
      @(posedge clock) reset_trig <= 1;
      @(posedge clock) reset_trig <= 0;
      apb(0, 16'h0014, 0);
      `CHK("fw reset", 1'b1, rd[0])
      apb(1, 16'h0014, 1);
      apb(0, 16'h0014, 0);
      `CHK("fw reset clr", 1'b0, rd[0])
      for (int b = 0; b < 60; b++) begin
         {fe, wk, glob, awake, lp, fwd} = {8'(rnd()) | 8'h01, 8'(rnd()), 1'(rnd()) | (b < 3), 3'(rnd())};
         if (b == 0) {lp, awake} = 2'b00;
         if (b == 1) {lp, wk} = 9'h1FF;
         low_power <= lp;
         apb(1, 16'h0000, {15'h0, awake, 8'h0, fe});
         apb(1, 16'h0004, {31'h0, glob});
         apb(1, 16'h0008, {24'h0, wk});
         apb(1, 16'h000C, 32'h0000_00FF);
         apb(1, 16'h001C, 32'h0000_0001);
         apb(1, 16'h0018, 32'h0000_007F);
         apb(0, 16'h000C, 0);
         `CHK("flags clr", 32'h0, rd)
         `CHK("irq low", 1'b0, irq)
         exp_fl = '0;
         any_off = 0;
         for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            if (i < 4) begin
               v[i] = rx_verdict_type'({4'((rnd() & rnd()) ^ 32'h9), 8'(rnd() & rnd()), 8'(rnd())});
               if (b == 2) v[i].crc_err = 1;
               pkt <= v[i];
            end
            pkt_valid <= (i < 4);
            @(negedge clock);
            if (i > 0) seen[i-1] = {offload_req, forward_host, wake_host, drop_packet};
         end
         for (int i = 0; i < 4; i++) begin
            expect_pkt(v[i]);
            exp_fl |= fl;
            any_off |= o[3];
            `CHK("outcome", o & care, seen[i] & care)
         end
         repeat (2) @(posedge clock);
         apb(0, 16'h000C, 0);
         `CHK("flags", {24'h0, exp_fl}, rd)
         `CHK("irq", any_off, irq)
      end
      repeat (30) @(posedge clock);
      {fe, glob, awake, lp} = {8'h01, 3'b110};
      slow <= 1;
      low_power <= 0;
      apb(1, 16'h0000, 32'h0001_0001);
      apb(1, 16'h0004, 32'h0000_0001);
      apb(1, 16'h0018, 32'h0000_007F);
      @(posedge clock);
      pkt <= '{1'b1, 1'b0, 1'b0, 1'b1, 8'h01, 8'h00};
      pkt_valid <= 1;
      @(posedge clock) pkt_valid <= 0;
      repeat (30) @(posedge clock);
      apb(0, 16'h0018, 0);
      `CHK("late", 2'b11, {rd[6], rd[0]})
      finish_test();
   end
endmodule
